// file: src/sio_host_decode.sv
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "sio_map.svh"
// Operation
// - XT mode: same input read as active-low hard disk DMA ack.
// - Power invalid: inputs ignored, all outputs released to high-Z.
// - Registers keep their contents while power is invalid.
// - Adapter mode: game port select low when address is 201h.
// - Four active-low open-drain motor outputs follow motor enable bits.
// - Drive selects decode drive number, qualified by matching motor bit.
// - Registers are 8 bits, IDE data register at 1F0 is 16 bits.
// - Power-up map: floppy, two serial, parallel and IDE default ranges.
// - Floppy, IDE, serial and parallel bases relocate via config regs.
// - Configuration entered by key sequence at 3F0; writes only then.
// - In configuration mode, reads of 3F1 return config register data.
// - Config mode hides status A/B; otherwise 3F0/3F1 read A/B.
// - XT mode decodes IDE at 320-323 and 3F5-3F7.
module sio_host_decode (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Host register port
  input  wire logic [9:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  output logic             rdata_oe_out,
  // Pins
  input  wire logic        power_valid_in,
  input  wire logic        io_width_indicator_in,
  input  wire logic        parallel_mode_strap_in,
  input  wire logic        disk_change_in,
  input  wire logic [7:0]  floppy_status_a_in,
  input  wire logic [7:0]  floppy_status_b_in,
  input  wire logic        ide_data_bit7_in,
  output logic             ide_data_bit7_out,
  output logic             ide_data_bit7_oe_out,
  output logic             game_port_select_n_out,
  output logic             game_port_select_oe_out,
  output logic      [3:0]  motor_enable_n_out,
  output logic      [3:0]  motor_enable_oe_out,
  output logic      [3:0]  drive_select_n_out,
  output logic      [3:0]  drive_select_oe_out,
  // Decode results toward function blocks
  output logic             io16_out,
  output logic             hard_disk_dma_ack_out,
  output logic             cs_floppy_out,
  output logic             cs_com1_out,
  output logic             cs_com2_out,
  output logic             cs_lpt_out,
  output logic             cs_ide_out,
  output logic             cs_ide_alt_out,
  output logic             parallel_mode_out,
  output logic             cfg_mode_out
);
  // ==========================================================
  // Synchronised pins
  logic pv_s, wid_s, strap_s, dchg_s, d7_s;

  sio_sync2 #(.W(5)) u_sync (
    .clk_sys_in (clk_sys_in),
    .d_in       ({power_valid_in, io_width_indicator_in,
                  parallel_mode_strap_in, disk_change_in,
                  ide_data_bit7_in}),
    .q_out      ({pv_s, wid_s, strap_s, dchg_s, d7_s})
  );

  // ==========================================================
  // Configuration state
  sio_pkg::sio_cfg_state_t cfg_state_r;
  logic [3:0]  cfg_index_r;
  logic [7:0]  cr_mode_r;
  logic [9:0]  fdc_base_r, ide_base_r, ide_alt_r;
  logic [9:0]  com1_base_r, com2_base_r, lpt_base_r;
  logic [7:0]  digital_output_reg_r;
  logic        strap_r;

  logic act, wr_act, rd_act, in_cfg, xt_mode, adpt_mode;
  logic hit_fdc, hit_com1, hit_com2, hit_lpt, hit_ide, hit_alt;
  logic [9:0] ide_b, alt_b;
  logic [7:0] cfg_rd;

  // Access only counts while power is valid
  assign act     = pv_s;
  assign wr_act  = act && wr_in;
  assign rd_act  = act && rd_in;
  assign in_cfg  = (cfg_state_r == sio_pkg::SIO_CFG_ON);
  assign xt_mode = cr_mode_r[`SIO_MODE_XT_BIT];
  assign adpt_mode = cr_mode_r[`SIO_MODE_ADPT_BIT];

  // ==========================================================
  // Key sequence: two key bytes to 3F0 enter, exit byte leaves
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cfg_state_r <= sio_pkg::SIO_CFG_IDLE;
    end else if (wr_act && addr_in == `SIO_A_CFG_INDEX) begin
      case (cfg_state_r)
        sio_pkg::SIO_CFG_IDLE:
          cfg_state_r <= (wdata_in == `SIO_CFG_KEY) ?
                         sio_pkg::SIO_CFG_KEY1 : sio_pkg::SIO_CFG_IDLE;
        sio_pkg::SIO_CFG_KEY1:
          cfg_state_r <= (wdata_in == `SIO_CFG_KEY) ?
                         sio_pkg::SIO_CFG_ON : sio_pkg::SIO_CFG_IDLE;
        sio_pkg::SIO_CFG_ON:
          if (wdata_in == `SIO_CFG_EXIT) begin
            cfg_state_r <= sio_pkg::SIO_CFG_IDLE;
          end
        default: cfg_state_r <= sio_pkg::SIO_CFG_IDLE;
      endcase
    end
  end

  // Index register, written at 3F0 while configuring
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cfg_index_r <= 4'h0;
    end else if (wr_act && in_cfg && addr_in == `SIO_A_CFG_INDEX &&
                 wdata_in != `SIO_CFG_EXIT) begin
      cfg_index_r <= wdata_in[3:0];
    end
  end

  // ==========================================================
  // Configuration registers; base fields hold address bits 9:3, the parallel base bits 9:2
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cr_mode_r   <= 8'h00;
      fdc_base_r  <= `SIO_FDC_BASE_RST;
      ide_base_r  <= `SIO_IDE_BASE_RST;
      ide_alt_r   <= `SIO_IDE_ALT_RST;
      com1_base_r <= `SIO_COM1_BASE_RST;
      com2_base_r <= `SIO_COM2_BASE_RST;
      lpt_base_r  <= `SIO_LPT_BASE_RST;
    end else if (wr_act && in_cfg && addr_in == `SIO_A_CFG_DATA) begin
      if (cfg_index_r == `SIO_CR_MODE) begin
        cr_mode_r <= wdata_in;
      end else if (cfg_index_r == `SIO_CR_FDC) begin
        fdc_base_r <= {wdata_in[6:0], 3'h0};
      end else if (cfg_index_r == `SIO_CR_IDE) begin
        ide_base_r <= {wdata_in[6:0], 3'h0};
        ide_alt_r  <= {wdata_in[6:0], 3'h0} + 10'h206;
      end else if (cfg_index_r == `SIO_CR_COM1) begin
        com1_base_r <= {wdata_in[6:0], 3'h0};
      end else if (cfg_index_r == `SIO_CR_COM2) begin
        com2_base_r <= {wdata_in[6:0], 3'h0};
      end else if (cfg_index_r == `SIO_CR_LPT) begin
        lpt_base_r <= {wdata_in[7:0], 2'h0};
      end
    end
  end

  // Read-back mux for configuration data
  always_comb begin
    if (cfg_index_r == `SIO_CR_MODE) begin
      cfg_rd = cr_mode_r;
    end else if (cfg_index_r == `SIO_CR_FDC) begin
      cfg_rd = {1'b0, fdc_base_r[9:3]};
    end else if (cfg_index_r == `SIO_CR_IDE) begin
      cfg_rd = {1'b0, ide_base_r[9:3]};
    end else if (cfg_index_r == `SIO_CR_COM1) begin
      cfg_rd = {1'b0, com1_base_r[9:3]};
    end else if (cfg_index_r == `SIO_CR_COM2) begin
      cfg_rd = {1'b0, com2_base_r[9:3]};
    end else if (cfg_index_r == `SIO_CR_LPT) begin
      cfg_rd = lpt_base_r[9:2];
    end else begin
      cfg_rd = 8'h00;
    end
  end

  // ==========================================================
  // Strap caught while reset is held
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      strap_r <= strap_s;
    end
  end

  // Digital output register at floppy base + 2
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      digital_output_reg_r <= `SIO_DOR_RST;
    end else if (wr_act && hit_fdc &&
                 addr_in[2:0] == `SIO_A_DOR_OFS) begin
      digital_output_reg_r <= wdata_in;
    end
  end

  // ==========================================================
  // Address decode
  assign ide_b = xt_mode ? `SIO_IDE_XT_BASE : ide_base_r;
  assign alt_b = xt_mode ? `SIO_IDE_XT_ALT  : ide_alt_r;

  // Floppy window; offset 6 belongs to the disk side
  sio_range #(.SPAN(8)) u_fdc (
    .addr_in (addr_in),
    .base_in (fdc_base_r),
    .en_in   (act && addr_in[2:0] != 3'h6),
    .hit_out (hit_fdc)
  );

  // First serial port window
  sio_range #(.SPAN(8)) u_com1 (
    .addr_in (addr_in),
    .base_in (com1_base_r),
    .en_in   (act),
    .hit_out (hit_com1)
  );

  // Second serial port window
  sio_range #(.SPAN(8)) u_com2 (
    .addr_in (addr_in),
    .base_in (com2_base_r),
    .en_in   (act),
    .hit_out (hit_com2)
  );

  // Parallel port window, three registers
  sio_range #(.SPAN(3)) u_lpt (
    .addr_in (addr_in),
    .base_in (lpt_base_r),
    .en_in   (act),
    .hit_out (hit_lpt)
  );

  // Disk task file window
  sio_range #(.SPAN(8)) u_ide (
    .addr_in (addr_in),
    .base_in (ide_b),
    .en_in   (act),
    .hit_out (hit_ide)
  );

  // Disk alternate status and control pair
  sio_range #(.SPAN(2)) u_alt (
    .addr_in (addr_in),
    .base_in (alt_b),
    .en_in   (act),
    .hit_out (hit_alt)
  );

  // ==========================================================
  // Registered chip selects and mode outputs
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cs_floppy_out     <= 1'b0;
      cs_com1_out       <= 1'b0;
      cs_com2_out       <= 1'b0;
      cs_lpt_out        <= 1'b0;
      cs_ide_out        <= 1'b0;
      cs_ide_alt_out    <= 1'b0;
      io16_out          <= 1'b0;
      hard_disk_dma_ack_out <= 1'b0;
      parallel_mode_out <= 1'b0;
      cfg_mode_out      <= 1'b0;
    end else begin
      cs_floppy_out     <= hit_fdc && !(in_cfg &&
                           (addr_in & 10'h3FE) == `SIO_A_CFG_INDEX);
      cs_com1_out       <= hit_com1;
      cs_com2_out       <= hit_com2;
      cs_lpt_out        <= hit_lpt;
      cs_ide_out        <= hit_ide && (!xt_mode || addr_in[2] == 1'b0);
      cs_ide_alt_out    <= hit_alt || (xt_mode && act &&
                           addr_in == `SIO_IDE_XT_ALT + 10'h2);
      io16_out          <= act && !xt_mode && !wid_s;
      hard_disk_dma_ack_out <= act && xt_mode && !wid_s;
      parallel_mode_out <= strap_r;
      cfg_mode_out      <= in_cfg;
    end
  end

  // ==========================================================
  // Host read data, one cycle after the read strobe
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_out    <= 16'h0000;
      rdata_oe_out <= 1'b0;
    end else begin
      rdata_oe_out <= 1'b0;
      rdata_out    <= 16'h0000;
      if (rd_act) begin
        if (in_cfg && addr_in == `SIO_A_CFG_DATA) begin
          rdata_out    <= {8'h00, cfg_rd};
          rdata_oe_out <= 1'b1;
        end else if (in_cfg && addr_in == `SIO_A_CFG_INDEX) begin
          rdata_oe_out <= 1'b0;
        end else if (addr_in == fdc_base_r) begin
          rdata_out    <= {8'h00, floppy_status_a_in};
          rdata_oe_out <= 1'b1;
        end else if (addr_in == fdc_base_r + 10'h1) begin
          rdata_out    <= {8'h00, floppy_status_b_in};
          rdata_oe_out <= 1'b1;
        end else if (hit_fdc && addr_in[2:0] == `SIO_A_DOR_OFS) begin
          rdata_out    <= {8'h00, digital_output_reg_r};
          rdata_oe_out <= 1'b1;
        end else if (hit_fdc && addr_in[2:0] == 3'h7) begin
          rdata_out    <= {8'h00, dchg_s, 7'h00};
          rdata_oe_out <= 1'b1;
        end else if (!xt_mode && (hit_ide || hit_alt)) begin
          rdata_out    <= {8'h00, d7_s, 7'h00};
          rdata_oe_out <= 1'b1;
        end
      end
    end
  end

  // IDE bit 7 buffer toward the drive on host writes
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ide_data_bit7_out    <= 1'b0;
      ide_data_bit7_oe_out <= 1'b0;
    end else begin
      ide_data_bit7_out    <= wdata_in[7];
      ide_data_bit7_oe_out <= wr_act && !xt_mode &&
                              (hit_ide || hit_alt);
    end
  end

  // ==========================================================
  // Game port select and drive pins; released when power invalid
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      game_port_select_n_out  <= 1'b1;
      game_port_select_oe_out <= 1'b0;
      motor_enable_n_out      <= 4'hF;
      motor_enable_oe_out     <= 4'h0;
      drive_select_n_out      <= 4'hF;
      drive_select_oe_out     <= 4'h0;
    end else begin
      game_port_select_n_out  <= !(adpt_mode &&
                                   addr_in == `SIO_A_GAME);
      game_port_select_oe_out <= act && adpt_mode;
      motor_enable_n_out      <= 4'h0;
      motor_enable_oe_out     <= act ? digital_output_reg_r[7:4]
                                     : 4'h0;
      drive_select_n_out      <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        drive_select_oe_out[i] <= act &&
          digital_output_reg_r[1:0] == 2'(i) &&
          digital_output_reg_r[4 + i];
      end
    end
  end
  // Register contents are untouched by power loss
endmodule : sio_host_decode

// file: src/sio_map.svh
`ifndef SIO_MAP_SVH
`define SIO_MAP_SVH
// Host I/O addresses (10-bit)
`define SIO_A_CFG_INDEX   10'h3F0
`define SIO_A_CFG_DATA    10'h3F1
`define SIO_A_GAME        10'h201
// Default block bases after power-up
`define SIO_FDC_BASE_RST  10'h3F0
`define SIO_COM1_BASE_RST 10'h3F8
`define SIO_COM2_BASE_RST 10'h2F8
`define SIO_LPT_BASE_RST  10'h278
`define SIO_IDE_BASE_RST  10'h1F0
`define SIO_IDE_ALT_RST   10'h3F6
// XT mode IDE ranges
`define SIO_IDE_XT_BASE   10'h320
`define SIO_IDE_XT_ALT    10'h3F5
// Security key byte, written twice in a row to enter configuration
`define SIO_CFG_KEY       8'h55
`define SIO_CFG_EXIT      8'hAA
// Configuration register indices
`define SIO_CR_MODE       4'h0
`define SIO_CR_FDC        4'h1
`define SIO_CR_IDE        4'h2
`define SIO_CR_COM1       4'h3
`define SIO_CR_COM2       4'h4
`define SIO_CR_LPT        4'h5
// Mode register field positions
`define SIO_MODE_XT_BIT   0
`define SIO_MODE_ADPT_BIT 1
// Digital output register reset value
`define SIO_DOR_RST       8'h00
`define SIO_A_DOR_OFS     3'h2
`endif

// file: src/sio_pkg.sv
package sio_pkg;
  // Configuration entry sequencer states
  typedef enum logic [1:0] {
    SIO_CFG_IDLE,
    SIO_CFG_KEY1,
    SIO_CFG_ON
  } sio_cfg_state_t;
endpackage : sio_pkg

// file: src/sio_range.sv
`timescale 1ns/100ps
// Compares an I/O address with a relocatable aligned window
module sio_range #(
  parameter int SPAN = 8
) (
  input  wire logic [9:0] addr_in,
  input  wire logic [9:0] base_in,
  input  wire logic       en_in,
  output logic            hit_out
);
  // ==========================================================
  // Window hit
  always_comb begin
    hit_out = en_in && (addr_in >= base_in) &&
              ({1'b0, addr_in} < ({1'b0, base_in} + 11'(SPAN)));
  end
endmodule : sio_range

// file: src/sio_sync2.sv
`timescale 1ns/100ps
// Two flip-flop synchroniser for pin inputs
module sio_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  // ==========================================================
  // Synchroniser stages
  always_ff @(posedge clk_sys_in) begin
    meta_r <= d_in;
    q_out  <= meta_r;
  end
endmodule : sio_sync2

// file: test/sio_host_decode_assertions.sv
`timescale 1ns/100ps
`include "sio_map.svh"
// ==========
// Port checks of the host decode block
module sio_host_decode_assertions (
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic [9:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        rdata_oe_out,
  input wire logic        power_valid_in,
  input wire logic [7:0]  floppy_status_a_in,
  input wire logic        ide_data_bit7_oe_out,
  input wire logic        game_port_select_n_out,
  input wire logic        game_port_select_oe_out,
  input wire logic [3:0]  motor_enable_n_out,
  input wire logic [3:0]  motor_enable_oe_out,
  input wire logic [3:0]  drive_select_n_out,
  input wire logic [3:0]  drive_select_oe_out,
  input wire logic        parallel_mode_out,
  input wire logic        cfg_mode_out
);
  logic [2:0] pv_sr_r;
  logic       key_r;
  logic       key2_r;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  // Power history and recent key writes
  always_ff @(posedge clk_sys_in) begin
    pv_sr_r <= {pv_sr_r[1:0], power_valid_in};
    key_r   <= wr_in && addr_in == `SIO_A_CFG_INDEX &&
               wdata_in == `SIO_CFG_KEY;
    key2_r  <= key_r;
  end
  // Exit byte while configuring with power settled
  sequence s_quit;
    cfg_mode_out && wr_in && addr_in == `SIO_A_CFG_INDEX &&
      wdata_in == `SIO_CFG_EXIT && (&pv_sr_r) && power_valid_in;
  endsequence
  sequence s_read_a;
    rd_in && addr_in == `SIO_A_CFG_INDEX && !cfg_mode_out ##1 rdata_oe_out;
  endsequence
  // ==========
  // Assertions
  a_cfg_enter: assert property (
    $rose(cfg_mode_out) |-> key_r || key2_r)
    else $error("config mode entered without key writes");
  a_cfg_exit: assert property (
    s_quit |=> ##[0:1] !cfg_mode_out)
    else $error("config mode kept after exit byte");
  a_cfg_hides_status: assert property (
    rd_in && addr_in == `SIO_A_CFG_INDEX |=>
      cfg_mode_out |-> !rdata_oe_out)
    else $error("status A answered in config mode");
  a_status_a_data: assert property (
    s_read_a |-> rdata_out[7:0] == $past(floppy_status_a_in))
    else $error("status A read returned wrong byte");
  a_game_sel_addr: assert property (
    game_port_select_oe_out |->
      game_port_select_n_out == ($past(addr_in) != `SIO_A_GAME))
    else $error("game select does not follow address");
  a_drive_sel_qual: assert property (
    $onehot0(drive_select_oe_out) &&
      (drive_select_oe_out & ~motor_enable_oe_out) == 4'h0)
    else $error("drive select not qualified by motor bit");
  a_open_drain_low: assert property (
    $past(rstn_in) |-> motor_enable_n_out == 4'h0 &&
      drive_select_n_out == 4'h0)
    else $error("open drain output driven high");
  a_ide_bit_drive: assert property (
    ide_data_bit7_oe_out |-> $past(wr_in))
    else $error("IDE bit 7 driven without a write");
  a_power_hiz: assert property (
    !power_valid_in [*4] |-> {rdata_oe_out, ide_data_bit7_oe_out,
      game_port_select_oe_out, motor_enable_oe_out,
      drive_select_oe_out} == 11'h000)
    else $error("output enabled while power invalid");
  a_strap_hold: assert property (
    $past(rstn_in, 2) |-> $stable(parallel_mode_out))
    else $error("strap value changed after reset");
endmodule : sio_host_decode_assertions

bind sio_host_decode sio_host_decode_assertions chk_u (
  .clk_sys_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .rdata_oe_out, .power_valid_in, .floppy_status_a_in,
  .ide_data_bit7_oe_out, .game_port_select_n_out, .game_port_select_oe_out,
  .motor_enable_n_out, .motor_enable_oe_out, .drive_select_n_out,
  .drive_select_oe_out, .parallel_mode_out, .cfg_mode_out
);

// file: test/sio_host_model.sv
`timescale 1ns/100ps
`include "sio_map.svh"
// ==========
// Host processor on the I/O bus
module sio_host_model (
  input  wire logic       clk_sys_in,
  output logic      [9:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  // Idle bus at time zero
  initial begin
    addr_out  = 10'h000;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // One write cycle; afterwards the bus shows the inverse, never stale data
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_sys_in);
    addr_out  <= ~a;
    wdata_out <= ~d;
    wr_out    <= 1'b0;
  endtask : wr
  // One read cycle; data stand just after the return
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_sys_in);
    addr_out <= ~a;
    rd_out   <= 1'b0;
  endtask : rd
  // Key byte twice to the index port
  task automatic enter_cfg();
    wr(`SIO_A_CFG_INDEX, `SIO_CFG_KEY);
    wr(`SIO_A_CFG_INDEX, `SIO_CFG_KEY);
  endtask : enter_cfg
  // Index then data
  task automatic cfg_set(input logic [3:0] idx, input logic [7:0] d);
    wr(`SIO_A_CFG_INDEX, {4'h0, idx});
    wr(`SIO_A_CFG_DATA, d);
  endtask : cfg_set
endmodule : sio_host_model

// file: test/tb_top.sv
`timescale 1ns/100ps
// ==========
// Self-checking bench for the host decode block
module tb_top;
  logic        clk_sys_in, rstn_in, wr_in, rd_in, power_valid_in;
  logic        io_width_indicator_in, parallel_mode_strap_in;
  logic        disk_change_in, ide_data_bit7_in, rdata_oe_out;
  logic        ide_data_bit7_out, ide_data_bit7_oe_out, io16_out;
  logic        game_port_select_n_out, game_port_select_oe_out;
  logic        hard_disk_dma_ack_out, cs_floppy_out, cs_com1_out;
  logic        cs_com2_out, cs_lpt_out, cs_ide_out, cs_ide_alt_out;
  logic        parallel_mode_out, cfg_mode_out;
  logic [3:0]  motor_enable_n_out, motor_enable_oe_out;
  logic [3:0]  drive_select_n_out, drive_select_oe_out;
  logic [7:0]  wdata_in, floppy_status_a_in, floppy_status_b_in;
  logic [9:0]  addr_in;
  logic [15:0] rdata_out;
  logic [9:0]  map_a [7] = '{10'h3F5, 10'h3FF, 10'h2F8, 10'h27A, 10'h1F0,
                             10'h3F6, 10'h27B};
  logic [5:0]  map_e [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
  int          n_errors, checks_done;

  sio_host_model hm_u (.clk_sys_in, .addr_out(addr_in), .wdata_out(wdata_in),
    .wr_out(wr_in), .rd_out(rd_in));
  sio_host_decode dut_u (.clk_sys_in, .rstn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .rdata_oe_out, .power_valid_in,
    .io_width_indicator_in, .parallel_mode_strap_in, .disk_change_in,
    .floppy_status_a_in, .floppy_status_b_in, .ide_data_bit7_in,
    .ide_data_bit7_out, .ide_data_bit7_oe_out, .game_port_select_n_out,
    .game_port_select_oe_out, .motor_enable_n_out, .motor_enable_oe_out,
    .drive_select_n_out, .drive_select_oe_out, .io16_out,
    .hard_disk_dma_ack_out, .cs_floppy_out, .cs_com1_out, .cs_com2_out,
    .cs_lpt_out, .cs_ide_out, .cs_ide_alt_out, .parallel_mode_out,
    .cfg_mode_out);

  // 100 MHz clock
  always #5 clk_sys_in = ~clk_sys_in;

  // ==========
  // Checking tasks
  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  // Read; compare enable and, when enabled, the low byte
  task automatic rd_chk(input string nm, input logic [9:0] a,
                        input logic [8:0] e);
    hm_u.rd(a);
    #1;
    chk(nm, {rdata_oe_out, rdata_out[7:0] & {8{rdata_oe_out}}}, e);
  endtask : rd_chk
  // Bounded wait for the configuration flag
  task automatic wait_cfg(input logic v);
    int k;
    for (k = 0; k < 8 && cfg_mode_out !== v; k++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk("config mode", cfg_mode_out, v);
    if (k == 8) begin
      final_report();
    end
  endtask : wait_cfg
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ==========
  // Main sequence
  initial begin
    clk_sys_in = 1'b0;
    rstn_in = 1'b0;
    power_valid_in = 1'b1;
    io_width_indicator_in = 1'b0;
    parallel_mode_strap_in = 1'b1;
    disk_change_in = 1'b1;
    ide_data_bit7_in = 1'b1;
    floppy_status_a_in = 8'h5A;
    floppy_status_b_in = 8'hC3;
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    parallel_mode_strap_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk("strap", parallel_mode_out, 1'b1);
    for (int i = 0; i < 7; i++) begin
      hm_u.rd(map_a[i]);
      #1;
      chk("selects", {cs_floppy_out, cs_com1_out, cs_com2_out, cs_lpt_out,
                      cs_ide_out, cs_ide_alt_out}, map_e[i]);
    end
    rd_chk("status a", 10'h3F0, {1'b1, 8'h5A});
    rd_chk("status b", 10'h3F1, {1'b1, 8'hC3});
    $display("map and status test done");
    for (int i = 0; i < 4; i++) begin
      hm_u.wr(10'h3F2, (8'h10 << i) | 8'(i));
      @(posedge clk_sys_in);
      #1;
      chk("motor", motor_enable_oe_out, 4'h1 << i);
      chk("drive", drive_select_oe_out, 4'h1 << i);
    end
    hm_u.wr(10'h3F2, 8'hE0);
    @(posedge clk_sys_in);
    #1;
    chk("unqualified drive", drive_select_oe_out, 4'h0);
    rd_chk("dor", 10'h3F2, {1'b1, 8'hE0});
    $display("drive output test done");
    hm_u.rd(10'h1F0);
    #1;
    chk("ide bit in", {io16_out, hard_disk_dma_ack_out, rdata_out[7]},
        3'h5);
    @(posedge clk_sys_in);
    ide_data_bit7_in <= 1'b0;
    io_width_indicator_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    hm_u.rd(10'h3F7);
    #1;
    chk("disk change", rdata_out[7], 1'b1);
    chk("8-bit width", io16_out, 1'b0);
    disk_change_in <= 1'b0;
    ide_data_bit7_in <= 1'b1;
    hm_u.wr(10'h1F7, 8'h80);
    #1;
    chk("ide bit out", {ide_data_bit7_oe_out, ide_data_bit7_out},
        2'h3);
    hm_u.wr(10'h3F6, 8'h00);
    #1;
    chk("ide bit alt", {ide_data_bit7_oe_out, ide_data_bit7_out},
        2'h2);
    hm_u.rd(10'h3F7);
    #1;
    chk("disk change low", rdata_out[7], 1'b0);
    $display("ide test done");
    hm_u.enter_cfg();
    wait_cfg(1'b1);
    rd_chk("hidden status", 10'h3F0, 9'h000);
    hm_u.cfg_set(4'h0, 8'h02);
    rd_chk("config data", 10'h3F1, {1'b1, 8'h02});
    hm_u.cfg_set(4'h3, 8'h7D);
    hm_u.wr(10'h3F0, 8'hAA);
    wait_cfg(1'b0);
    hm_u.wr(10'h3F1, 8'h00);
    hm_u.rd(10'h201);
    #1;
    chk("game", {game_port_select_oe_out, game_port_select_n_out},
        2'h2);
    hm_u.rd(10'h3E8);
    #1;
    chk("moved com1", cs_com1_out, 1'b1);
    hm_u.rd(10'h3F8);
    #1;
    chk("old com1", cs_com1_out, 1'b0);
    $display("configuration test done");
    io_width_indicator_in <= 1'b0;
    hm_u.enter_cfg();
    hm_u.cfg_set(4'h0, 8'h01);
    hm_u.wr(10'h3F0, 8'hAA);
    hm_u.rd(10'h320);
    #1;
    chk("xt ide", {cs_ide_out, hard_disk_dma_ack_out}, 2'h3);
    hm_u.rd(10'h1F0);
    #1;
    chk("at ide off", cs_ide_out, 1'b0);
    hm_u.wr(10'h1F7, 8'h80);
    #1;
    chk("xt bit 7", ide_data_bit7_oe_out, 1'b0);
    $display("xt mode test done");
    @(posedge clk_sys_in);
    power_valid_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    #1;
    chk("standby", {motor_enable_oe_out, ide_data_bit7_oe_out},
        5'h00);
    rd_chk("standby read", 10'h3F2, 9'h000);
    hm_u.wr(10'h3F2, 8'h00);
    @(posedge clk_sys_in);
    power_valid_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1;
    chk("kept motor", motor_enable_oe_out, 4'hE);
    rd_chk("kept dor", 10'h3F2, {1'b1, 8'hE0});
    floppy_status_a_in <= 8'hA5;
    rd_chk("status a new", 10'h3F0, {1'b1, 8'hA5});
    $display("power test done");
    final_report();
  end
endmodule : tb_top
